// >>> epv_ctrl.sv
// Program/verify controller for the one-time-programmable code store, key array
// and security bits. Assumes an external programmer drives the pins; every pin
// enters through a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module epv_ctrl
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 serial_in,
    input  wire logic                 program_strobe_n,
    input  wire logic                 program_pulse_pin_voltage,
    input  wire logic                 address_half_select,
    input  wire logic [7:0]           addr_port,
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic      [7:0]           data_oe_n,
    output logic                      sec_bit1,
    output logic                      sec_bit2,
    output logic      [2:0]           mode_state
);
    import epv_pkg::*;

    // Synchronised pin images.
    logic [7:0] s_addr;
    logic [7:0] s_data;
    logic       s_ser;
    logic       s_strb_n;
    logic       s_vpp;
    logic       s_address_half_select;
    logic [3:0] ctl_raw;
    logic [3:0] ctl_sync;

    assign ctl_raw = {serial_in, program_strobe_n, program_pulse_pin_voltage, address_half_select};

    // Control pins share one synchroniser bank.
    epv_sync #(.W(4)) u_sync_ctl (
        .clk   (clk),
        .reset (reset),
        .din   (ctl_raw),
        .dout  (ctl_sync)
    );

    // Address port synchroniser.
    epv_sync #(.W(8)) u_sync_addr (
        .clk   (clk),
        .reset (reset),
        .din   (addr_port),
        .dout  (s_addr)
    );

    // Data port synchroniser.
    epv_sync #(.W(8)) u_sync_data (
        .clk   (clk),
        .reset (reset),
        .din   (data_in),
        .dout  (s_data)
    );

    assign s_ser    = ctl_sync[3];
    assign s_strb_n = ctl_sync[2];
    assign s_vpp    = ctl_sync[1];
    assign s_address_half_select   = ctl_sync[0];

    // Storage arrays. Erased state is all ones.
    logic [7:0] code_mem [CODE_DEPTH];  // User code store.
    logic [7:0] key_mem  [KEY_DEPTH];   // Encryption key array.

    // Mode decoding is used once, when a code completes, and is kept as a function.
    function automatic epv_mode_t decode_code(input logic [9:0] c);
        case (c)
            CODE_USER: decode_code = EPV_USER;
            CODE_KEY:  decode_code = EPV_KEY;
            CODE_SEC1: decode_code = EPV_SEC1;
            CODE_SEC2: decode_code = EPV_SEC2;
            default:   decode_code = EPV_IDLE;
        endcase
    endfunction

    // Serial shift state.
    logic [9:0] shift;      // Code bits, filled from the top, LSB first.
    logic [3:0] bit_cnt;    // Number of bits captured so far.
    epv_mode_t  mode;       // Operation chosen by the received code.
    logic       armed;      // Serial line has been high; code stream may start.

    // Capture the code: the pin is sampled each clock edge (clock high period),
    // one bit per clock, starting at the first low bit after the serial line has been held high.
    // Code 296H begins with a 0 bit, as do all listed codes, so the first
    // falling level of the stream marks its start.
    always_ff @(posedge clk) begin
        if (reset) begin
            shift   <= 10'h000;
            bit_cnt <= 4'h0;
            mode    <= EPV_IDLE;
            armed   <= 1'b0;
        end else begin
            // A high level after a finished code rearms the receiver, so a
            // later code can be taken without a full reset.
            if (s_ser && (bit_cnt == 4'h0 || bit_cnt == 4'(CODE_BITS))) begin
                armed   <= 1'b1;
                bit_cnt <= 4'h0;
            end else if (armed && (bit_cnt != 4'h0 || !s_ser) && bit_cnt < 4'(CODE_BITS)) begin
                shift   <= {s_ser, shift[9:1]};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'(CODE_BITS - 1)) begin
                    mode  <= decode_code({s_ser, shift[9:1]});
                    armed <= 1'b0;
                end
            end
        end
    end

    // Multiplexed address: high bits taken when half-select falls.
    logic [HI_BITS-1:0] addr_hi;
    logic               address_half_select_d;
    logic [ADDR_BITS-1:0] addr;

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_hi <= '0;
            address_half_select_d  <= 1'b0;
        end else begin
            address_half_select_d <= s_address_half_select;
            if (address_half_select_d && !s_address_half_select) begin
                addr_hi <= s_addr[HI_BITS-1:0];
            end
        end
    end

    assign addr = {addr_hi, s_addr};

    // Security bits, set by program pulses and cleared only by reset.
    logic sec1;
    logic sec2;

    // Programming pulses: count strobe falls under programming voltage.
    logic       strb_d;
    logic [4:0] pulse_cnt;
    logic       did_program_pulse_pin;     // A program cycle ran since mode entry.
    logic       program_pulse_pin_fire;
    logic       program_pulse_pin_allow;

    assign program_pulse_pin_allow = !sec1;
    assign program_pulse_pin_fire  = s_vpp && strb_d && !s_strb_n;

    // The cell is written on the first pulse; later pulses only repeat it.
    // A real cell needs the whole train, but the stored value is the same.
    always_ff @(posedge clk) begin
        if (reset) begin
            strb_d    <= 1'b1;
            pulse_cnt <= 5'h00;
            did_program_pulse_pin  <= 1'b0;
        end else begin
            strb_d <= s_strb_n;
            // A new code starts a pure verify sequence, so the short bound applies.
            if (armed) begin
                did_program_pulse_pin <= 1'b0;
            end
            if (!s_vpp) begin
                pulse_cnt <= 5'h00;
            end else if (program_pulse_pin_fire && pulse_cnt != PULSES_W) begin
                pulse_cnt <= pulse_cnt + 5'h01;
                did_program_pulse_pin  <= 1'b1;
            end
        end
    end

    // Array and security-bit writes. Ones-to-zero programming is modelled as AND.
    always_ff @(posedge clk) begin
        if (reset) begin
            sec1 <= 1'b0;
            sec2 <= 1'b0;
        end else if (program_pulse_pin_fire) begin
            case (mode)
                EPV_USER: begin
                    if (program_pulse_pin_allow) begin
                        code_mem[addr] <= code_mem[addr] & s_data;
                    end
                end
                EPV_KEY: begin
                    if (program_pulse_pin_allow) begin
                        key_mem[addr[3:0]] <= key_mem[addr[3:0]] & s_data;
                    end
                end
                EPV_SEC1: begin
                    sec1 <= 1'b1;
                end
                EPV_SEC2: begin
                    sec2 <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Initial erased contents of both arrays.
    initial begin
        for (int i = 0; i < CODE_DEPTH; i++) begin
            code_mem[i] = ERASED;
        end
        for (int k = 0; k < KEY_DEPTH; k++) begin
            key_mem[k] = ERASED;
        end
    end

    // Verify: data settles after a delay that depends on history.
    logic [5:0]           wait_cnt;
    logic [ADDR_BITS-1:0] addr_d;
    logic                 vfy_level;
    logic                 vfy_ok;
    logic [5:0]           wait_len;

    assign vfy_level = !s_vpp && s_strb_n;
    assign wait_len  = did_program_pulse_pin ? SLOW_VFY_W : PURE_VFY_W;

    // The wait restarts on entry into verify and on any address change.
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_cnt <= 6'h00;
            addr_d   <= '0;
        end else begin
            addr_d <= addr;
            if (!vfy_level || addr != addr_d) begin
                wait_cnt <= 6'h00;
            end else if (wait_cnt != 6'h3f) begin
                wait_cnt <= wait_cnt + 6'h01;
            end
        end
    end

    // Data is shown a few cycles early to absorb the output register and sync.
    assign vfy_ok = vfy_level && (wait_cnt >= wait_len - 6'h04);

    // Verify data path with encryption and inhibits.
    logic [7:0] next_data;

    always_comb begin
        next_data = 8'h00;
        case (mode)
            EPV_USER: begin
                if (!sec2) begin
                    next_data = ~(code_mem[addr] ^ key_mem[addr[3:0]]);
                end
            end
            EPV_KEY: begin
                if (!sec1 && !sec2) begin
                    next_data = key_mem[addr[3:0]];
                end
            end
            EPV_SEC1: begin
                next_data[SEC1_POS] = sec1;
                next_data[SEC2_POS] = sec2;
            end
            default: begin
                next_data = 8'h00;
            end
        endcase
    end

    // Output register; the port drives only once the verify data is valid.
    always_ff @(posedge clk) begin
        if (reset) begin
            data_out  <= 8'h00;
            data_oe_n <= 8'hff;
        end else if (vfy_ok && mode != EPV_IDLE && mode != EPV_SEC2) begin
            data_out  <= next_data;
            data_oe_n <= 8'h00;
        end else begin
            data_out  <= 8'h00;
            data_oe_n <= 8'hff;
        end
    end

    // Status outputs, registered.
    always_ff @(posedge clk) begin
        if (reset) begin
            sec_bit1   <= 1'b0;
            sec_bit2   <= 1'b0;
            mode_state <= 3'b000;
        end else begin
            sec_bit1   <= sec1;
            sec_bit2   <= sec2;
            mode_state <= mode;
        end
    end
endmodule
`default_nettype wire

// >>> epv_ctrl_monitor.sv
// Checker for epv_ctrl: modes, verify data, security locks and verify timing.
// Assumes the single clk domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module epv_ctrl_monitor
    import epv_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       serial_in,
    input wire logic       program_strobe_n,
    input wire logic       program_pulse_pin_voltage,
    input wire logic       address_half_select,
    input wire logic [7:0] addr_port,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic       sec_bit1,
    input wire logic       sec_bit2,
    input wire logic [2:0] mode_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // A user verify starts when the voltage pin drops while reads are allowed.
    sequence user_vfy;
        mode_state == EPV_USER && !sec_bit2 && $fell(program_pulse_pin_voltage);
    endsequence
    // Four cycles in one mode skip the cycles where the port still settles.
    sequence mode_held(logic [2:0] m);
        mode_state == m && $past(mode_state, 4) == m;
    endsequence
    a_idle_quiet: assert property (mode_state == EPV_IDLE |-> data_oe_n == 8'hff)
        else $error("port driven while idle");
    a_sec2_quiet: assert property (mode_state == EPV_SEC2 |-> data_oe_n == 8'hff)
        else $error("port driven in security two mode");
    a_sec_bits_out: assert property (mode_state == EPV_SEC1 && data_oe_n == 8'h00
        |-> data_out == {sec_bit1, sec_bit2, 6'h00})
        else $error("security verify data wrong");
    a_key_locked: assert property (mode_held(EPV_KEY) and (sec_bit1 || sec_bit2)
        |-> data_oe_n == 8'hff || data_out == 8'h00)
        else $error("key data shown while locked");
    a_user_locked: assert property (mode_held(EPV_USER) and sec_bit2
        |-> data_oe_n == 8'hff || data_out == 8'h00)
        else $error("code data shown while locked");
    a_sec1_cause: assert property ($rose(sec_bit1) |-> mode_state == EPV_SEC1)
        else $error("security one set outside its mode");
    a_sec2_cause: assert property ($rose(sec_bit2) |-> mode_state == EPV_SEC2)
        else $error("security two set outside its mode");
    a_sec_one_time: assert property (sec_bit1 |=> sec_bit1)
        else $error("security one cleared");
    a_vfy_bound: assert property (user_vfy |-> ##[1:48] data_oe_n == 8'h00)
        else $error("verify data late");
    a_program_pulse_pin_input: assert property (program_pulse_pin_voltage [*4] |-> data_oe_n == 8'hff)
        else $error("port driven at programming voltage");
endmodule
bind epv_ctrl epv_ctrl_monitor u_epv_ctrl_monitor (.clk(clk), .reset(reset),
    .serial_in(serial_in), .program_strobe_n(program_strobe_n),
    .program_pulse_pin_voltage(program_pulse_pin_voltage), .address_half_select(address_half_select),
    .addr_port(addr_port), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .sec_bit1(sec_bit1), .sec_bit2(sec_bit2),
    .mode_state(mode_state));
`default_nettype wire

// >>> epv_pkg.sv
// Package for the program/verify and security controller of the code store.
// Assumes a single 40 MHz clock domain and plain-port control from the chip top.
package epv_pkg;
    // Serial mode codes, ten bits, shifted in LSB first.
    localparam logic [9:0] CODE_USER     = 10'h296;
    localparam logic [9:0] CODE_KEY      = 10'h292;
    localparam logic [9:0] CODE_SEC1     = 10'h29a;
    localparam logic [9:0] CODE_SEC2     = 10'h298;
    localparam int         CODE_BITS     = 10;
    // Array geometry.
    localparam int         ADDR_BITS     = 11;
    localparam int         CODE_DEPTH    = 2048;
    localparam int         KEY_DEPTH     = 16;
    localparam int         HI_BITS       = 3;
    localparam logic [7:0] ERASED        = 8'hff;
    // Bit positions of the security flags on a security verify.
    localparam int         SEC1_POS      = 7;
    localparam int         SEC2_POS      = 6;
    // Timing counts in clock periods.
    localparam int         PURE_VFY_CYC  = 14;
    localparam int         ADDR_VFY_CYC  = 48;
    localparam int         PROGRAM_PULSE_PIN_VFY_CYC  = 48;
    localparam int         PULSES        = 25;
    localparam logic [5:0] PURE_VFY_W    = 6'h0e;
    localparam logic [5:0] SLOW_VFY_W    = 6'h30;
    localparam logic [4:0] PULSES_W      = 5'h19;
    // Decoded operation modes.
    typedef enum logic [2:0] {
        EPV_IDLE = 3'b000,
        EPV_USER = 3'b001,
        EPV_KEY  = 3'b010,
        EPV_SEC1 = 3'b011,
        EPV_SEC2 = 3'b100
    } epv_mode_t;
endpackage

// >>> epv_program_pulse_pin_model.sv
// Programmer model that drives the code store pins on falling clock edges.
// Assumes the caller orders code, address, pulses and verify.
`timescale 1ns/1ps
`default_nettype none
module epv_program_pulse_pin_model #(
    parameter int PW  = 40, // Strobe low cycles; shortened to keep runs brief.
    parameter int GAP = 48  // Strobe high cycles; also covers the address hold.
) (
    input  wire logic       clk,
    output logic            serial_in,
    output logic            program_strobe_n,
    output logic            program_pulse_pin_voltage,
    output logic            address_half_select,
    output logic [7:0]      addr_port,
    output logic [7:0]      data_in
);
    // Pins start idle with the strobe high.
    initial begin
        serial_in = 1'b0;
        program_strobe_n = 1'b1;
        program_pulse_pin_voltage = 1'b0;
        address_half_select = 1'b0;
        addr_port = 8'h00;
        data_in = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // The line is held high for four cycles, then ten bits go out lowest first.
    task automatic send_code(input logic [9:0] c);
        serial_in = 1'b1;
        tick(4);
        for (int i = 0; i < 10; i++) begin
            serial_in = c[i];
            tick(1);
        end
        serial_in = 1'b0;
        tick(8);
    endtask
    // One access: optional address, voltage high, optional pulses, voltage low.
    task automatic op(input logic [10:0] a, input logic [7:0] d, input bit pgm, input bit adr);
        if (adr) begin
            address_half_select = 1'b1;
            addr_port = {5'h00, a[10:8]};
            tick(13);
            address_half_select = 1'b0;
            tick(2);
            addr_port = a[7:0];
            tick(24);
        end
        program_pulse_pin_voltage = 1'b1;
        data_in = d;
        tick(38);
        if (pgm) begin
            repeat (25) begin
                program_strobe_n = 1'b0;
                tick(PW);
                program_strobe_n = 1'b1;
                tick(GAP);
            end
        end
        // The released bus shows the inverse so a stale value cannot pass.
        data_in = ~d;
        program_pulse_pin_voltage = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> epv_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes pins are asynchronous to clk; only the second stage reads the first stage.
`timescale 1ns/1ps
`default_nettype none
module epv_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;  // First stage, read only by the second.

    // Both stages clear on reset so outputs are defined.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> test_epv_ctrl.sv
// Self-checking bench for epv_ctrl with the programmer model on its pins.
// Assumes the 40 MHz clock; results are compared from a queue of notes.
`timescale 1ns/1ps
`default_nettype none
module test_epv_ctrl;
    import epv_pkg::*;
    logic       clk, reset, serial_in, program_strobe_n, program_pulse_pin_voltage, address_half_select;
    logic [7:0] addr_port, data_in, data_out, data_oe_n;
    logic       sec_bit1, sec_bit2;
    logic [2:0] mode_state;
    int         n_fail, cmp_count, seed;
    logic [8:0] exp_q[$]; // Expected {driving, data} notes.
    event       look;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    epv_program_pulse_pin_model program_pulse_pin (.clk(clk), .serial_in(serial_in), .program_strobe_n(program_strobe_n),
        .program_pulse_pin_voltage(program_pulse_pin_voltage), .address_half_select(address_half_select),
        .addr_port(addr_port), .data_in(data_in));
    epv_ctrl u_epv_ctrl (.clk(clk), .reset(reset), .serial_in(serial_in),
        .program_strobe_n(program_strobe_n), .program_pulse_pin_voltage(program_pulse_pin_voltage),
        .address_half_select(address_half_select), .addr_port(addr_port),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .sec_bit1(sec_bit1), .sec_bit2(sec_bit2), .mode_state(mode_state));
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // The watcher takes the oldest note whenever a verify result is due.
    always @(look) begin
        check({data_oe_n === 8'h00, data_out}, exp_q.pop_front());
    end
    // Enter a code, then confirm the decoded mode.
    task automatic code(input logic [9:0] c, input logic [2:0] m);
        program_pulse_pin.send_code(c);
        check({6'h00, mode_state}, {6'h00, m});
    endtask
    // One access, then the result is looked at exactly lim cycles later.
    task automatic run(input logic [10:0] a, input logic [7:0] d, input bit pgm,
                       input bit adr, input logic [8:0] want, input int lim);
        program_pulse_pin.op(a, d, pgm, adr);
        exp_q.push_back(want);
        repeat (lim) @(posedge clk);
        @(negedge clk);
        ->look;
    endtask
    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
    initial begin
        logic [7:0] d0, d1, k0;
        seed = 52105;
        n_fail = 0;
        cmp_count = 0;
        reset = 1'b1;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        code(10'h2a4, EPV_IDLE);
        run(11'h000, 8'h00, 1'b1, 1'b1, 9'h000, 48);
        code(CODE_KEY, EPV_KEY);
        k0 = $random(seed);
        d0 = $random(seed);
        d1 = $random(seed);
        run(11'h000, k0, 1'b1, 1'b1, {1'b1, k0}, 48);
        code(CODE_USER, EPV_USER);
        run(11'h000, d0, 1'b1, 1'b1, {1'b1, ~(d0 ^ k0)}, 48);
        run(11'h511, d1, 1'b1, 1'b1, {1'b1, d1}, 48);
        run(11'h010, d1, 1'b1, 1'b1, {1'b1, ~(d1 ^ k0)}, 48);
        code(CODE_USER, EPV_USER);
        run(11'h000, 8'h00, 1'b0, 1'b1, {1'b1, ~(d0 ^ k0)}, 14);
        code(CODE_SEC1, EPV_SEC1);
        run(11'h000, 8'h00, 1'b0, 1'b0, 9'h100, 14);
        run(11'h000, 8'h00, 1'b1, 1'b0, 9'h180, 48);
        // Locked: a key write and a key read are both refused.
        code(CODE_KEY, EPV_KEY);
        program_pulse_pin.op(11'h001, 8'h00, 1'b1, 1'b1);
        program_pulse_pin.op(11'h000, 8'h00, 1'b0, 1'b1);
        code(CODE_USER, EPV_USER);
        run(11'h511, ~d1, 1'b1, 1'b1, {1'b1, d1}, 48);
        code(CODE_SEC2, EPV_SEC2);
        program_pulse_pin.op(11'h000, 8'h00, 1'b1, 1'b0);
        code(CODE_SEC1, EPV_SEC1);
        run(11'h000, 8'h00, 1'b0, 1'b0, 9'h1c0, 14);
        code(CODE_USER, EPV_USER);
        run(11'h000, 8'h00, 1'b0, 1'b1, 9'h100, 48);
        check({7'h00, sec_bit1, sec_bit2}, 9'h003);
        end_of_test;
    end
endmodule
`default_nettype wire
